// ===== design/eem_monitor.sv
/*
  Emulator exception monitor: watches target bus accesses, stack pointer,
  task identity, trace store and profile activity; raises sticky event flags
  and single-cycle break/trace qualifiers. Registers sit on a classic Wishbone
  slave. All monitor inputs come from emulator logic on clk_i.
*/
// Behaviour
// RL1: Six selectable profile tick intervals, 10 ns-1.6 us
// RL2: Changing tick interval clears accumulated profile results
// RL3: Profile time is a 40-bit tick counter
// RL4: Pass counter is 16 bits, max 65535
// RL5: Profile time or pass overflow raises event
// RL6: Section timer overflow raises performance event
// RL7: Disallowed access type raises protection violation
// RL8: Reading never-written location raises uninitialised event; code tracks only the 256 words from init_base
// RL9: Stack pointer outside bounds raises stack event
// RL10: Trace store overflow raises trace event
// RL11: Write into another task's stack raises event
// RL12: Observed task switch raises dispatch event
// RL13: Five attributes settable per word, any area
// RL14: Disabled-except-OS faults any non-OS access
// RL15: After reset every address is read-write
// RL16: Sixteen protection blocks; unassigned areas unprotected
// RL17: Write RO, read WO, anything disabled faults
// RL18: Each event selectable for break or trace
// RL19: Sticky flags until cleared, plus one-cycle pulses
// RL20: Three-bit attribute code per block region
`timescale 1ns/100ps
module eem_monitor (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // Wishbone classic slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [eem_pkg::WB_AW-1:0]   wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [eem_pkg::DATA_W-1:0]  wb_dat_i,
  output logic      [eem_pkg::DATA_W-1:0]  wb_dat_o,
  output logic                             wb_ack_o,
  // Target bus monitor
  input  wire logic                        mon_valid_i,
  input  wire logic [1:0]                  mon_kind_i,
  input  wire logic [eem_pkg::ADDR_W-1:0]  mon_addr_i,
  input  wire logic                        mon_os_i,
  input  wire logic                        mon_sp_valid_i,
  input  wire logic [eem_pkg::ADDR_W-1:0]  mon_sp_i,
  input  wire logic                        mon_task_valid_i,
  input  wire logic [eem_pkg::TASK_W-1:0]  mon_task_i,
  input  wire logic                        trace_wr_i,
  input  wire logic                        trace_full_i,
  input  wire logic                        prof_run_i,
  input  wire logic                        prof_enter_i,
  input  wire logic                        perf_run_i,
  // Event outputs
  output logic      [eem_pkg::NUM_EV-1:0]  event_pulse_o,
  output logic      [eem_pkg::NUM_EV-1:0]  event_flags_o,
  output logic                             break_o,
  output logic                             trace_o
);
  typedef struct packed {
    logic                                          ack;
    logic [eem_pkg::DATA_W-1:0]                    rdat;
    logic [2:0]                                    tick_sel;
    logic                                          stk_en;
    logic [eem_pkg::NUM_EV-1:0]                    flags;
    logic [eem_pkg::NUM_EV-1:0]                    brk_sel;
    logic [eem_pkg::NUM_EV-1:0]                    trc_sel;
    logic [eem_pkg::NUM_EV-1:0]                    evp;
    logic                                          brk;
    logic                                          trc;
    logic [eem_pkg::PTIME_W-1:0]                   ptime;
    logic [eem_pkg::PASS_W-1:0]                    pass;
    logic [eem_pkg::SECT_W-1:0]                    sect;
    logic [eem_pkg::DIV_W-1:0]                     divcnt;
    logic [eem_pkg::ADDR_W-1:0]                    stk_lo;
    logic [eem_pkg::ADDR_W-1:0]                    stk_hi;
    logic [eem_pkg::ADDR_W-1:0]                    init_base;
    logic [eem_pkg::MAP_WORDS-1:0]                 written;
    logic [eem_pkg::NUM_BLK-1:0][eem_pkg::ADDR_W-1:0]  blk_start;
    logic [eem_pkg::NUM_BLK-1:0][eem_pkg::ADDR_W-1:0]  blk_end;
    logic [eem_pkg::NUM_BLK-1:0][2:0]                  blk_attr;
    logic [eem_pkg::NUM_BLK-1:0]                       blk_valid;
    logic [eem_pkg::NUM_TSTK-1:0][eem_pkg::ADDR_W-1:0] ts_start;
    logic [eem_pkg::NUM_TSTK-1:0][eem_pkg::ADDR_W-1:0] ts_end;
    logic [eem_pkg::NUM_TSTK-1:0][eem_pkg::TASK_W-1:0] ts_owner;
    logic [eem_pkg::NUM_TSTK-1:0]                      ts_valid;
    logic [eem_pkg::TASK_W-1:0]                    prev_task;
    logic                                          task_seen;
  } eem_state_t;

  eem_state_t s;
  eem_state_t next_s;

  // Byte-lane merge of a Wishbone write into an old word
  function automatic logic [31:0] eem_merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] sel);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Cycles per counting step for a tick setting
  function automatic logic [eem_pkg::DIV_W-1:0] eem_div(input logic [2:0] sel);
    logic [eem_pkg::DIV_W-1:0] r;
    r = '0;
    for (int k = 0; k < eem_pkg::NUM_TICK; k++) begin
      if (sel == 3'(k)) begin
        r = eem_pkg::DIV_W'(eem_pkg::tick_div(eem_pkg::TICK_NS[k]));
      end
    end
    return r;
  endfunction

  // Ticks added per counting step for a tick setting
  function automatic logic [2:0] eem_inc(input logic [2:0] sel);
    logic [2:0] r;
    r = '0;
    for (int k = 0; k < eem_pkg::NUM_TICK; k++) begin
      if (sel == 3'(k)) begin
        r = 3'(eem_pkg::tick_inc(eem_pkg::TICK_NS[k]));
      end
    end
    return r;
  endfunction

  // Wishbone decode helpers
  logic        req;
  logic        bus_wr;
  logic [31:0] wold;
  logic [31:0] wval;
  logic [3:0]  widx;
  logic [1:0]  wfld;
  logic [3:0]  wwin;

  assign req    = wb_cyc_i & wb_stb_i;
  assign bus_wr = req & wb_ack_o & wb_we_i; // Write lands on the ack edge
  assign wwin   = wb_adr_i[11:8];
  assign widx   = wb_adr_i[7:4];
  assign wfld   = wb_adr_i[3:2];

  // Register read mux; also the old value used for byte-lane merges
  always_comb begin
    wold = '0;
    if (wwin == eem_pkg::WIN_BLK) begin
      unique case (wfld)
        eem_pkg::FLD_START: wold = 32'(s.blk_start[widx]);
        eem_pkg::FLD_END:   wold = 32'(s.blk_end[widx]);
        eem_pkg::FLD_ATTR:  wold = 32'({s.blk_valid[widx], s.blk_attr[widx]});
        default:            wold = '0;
      endcase
    end else if (wwin == eem_pkg::WIN_TSTK && widx < 4'(eem_pkg::NUM_TSTK)) begin
      unique case (wfld)
        eem_pkg::FLD_START: wold = 32'(s.ts_start[widx[1:0]]);
        eem_pkg::FLD_END:   wold = 32'(s.ts_end[widx[1:0]]);
        eem_pkg::FLD_ATTR:  wold = 32'({s.ts_valid[widx[1:0]], s.ts_owner[widx[1:0]]});
        default:            wold = '0;
      endcase
    end else begin
      unique case ({wb_adr_i[11:2], 2'b00})
        eem_pkg::REG_CTRL:      wold = 32'({s.stk_en, s.tick_sel});
        eem_pkg::REG_STATUS:    wold = 32'(s.flags);
        eem_pkg::REG_BRK_SEL:   wold = 32'(s.brk_sel);
        eem_pkg::REG_TRC_SEL:   wold = 32'(s.trc_sel);
        eem_pkg::REG_PTIME_LO:  wold = s.ptime[31:0];
        eem_pkg::REG_PTIME_HI:  wold = 32'(s.ptime[eem_pkg::PTIME_W-1:32]);
        eem_pkg::REG_PASS:      wold = 32'(s.pass);
        eem_pkg::REG_SECT:      wold = s.sect;
        eem_pkg::REG_STK_LO:    wold = 32'(s.stk_lo);
        eem_pkg::REG_STK_HI:    wold = 32'(s.stk_hi);
        eem_pkg::REG_INIT_BASE: wold = 32'(s.init_base);
        default:                wold = '0; // Unmapped reads return zero
      endcase
    end
    wval = eem_merge(wold, wb_dat_i, wb_sel_i);
  end

  // Attribute lookup: lowest-numbered valid block covering the address wins
  logic [2:0] attr;
  always_comb begin
    attr = eem_pkg::ATTR_RW; // Uncovered addresses stay read-write [RL15] [RL16]
    for (int i = eem_pkg::NUM_BLK-1; i >= 0; i--) begin
      if (s.blk_valid[i] && mon_addr_i >= s.blk_start[i] && mon_addr_i <= s.blk_end[i]) begin
        attr = s.blk_attr[i]; // Per-region code, any area of the space [RL13] [RL20]
      end
    end
  end

  // Task-stack ownership check, one comparator set per slot
  logic [eem_pkg::NUM_TSTK-1:0] ts_hit;
  genvar g;
  generate
    for (g = 0; g < eem_pkg::NUM_TSTK; g++) begin : g_tstk
      assign ts_hit[g] = s.ts_valid[g] && mon_addr_i >= s.ts_start[g] && mon_addr_i <= s.ts_end[g]
                         && s.ts_owner[g] != mon_task_i; // Foreign owner only [RL11]
    end
  endgenerate

  // Next-state logic
  logic [eem_pkg::NUM_EV-1:0]    ev;
  logic [eem_pkg::NUM_EV-1:0]    w1c;
  logic                          is_rd;
  logic                          is_wr;
  logic                          tick;
  logic                          clr_meas;
  logic                          clr_map;
  logic [eem_pkg::PTIME_W:0]     tsum;
  logic [eem_pkg::SECT_W:0]      ssum;
  logic [eem_pkg::ADDR_W-1:0]    moff;
  logic [2:0]                    inc;
  always_comb begin
    next_s   = s;
    ev       = '0;
    w1c      = '0;
    clr_meas = 1'b0;
    clr_map  = 1'b0;
    is_rd    = mon_valid_i && mon_kind_i == eem_pkg::ACC_READ;
    is_wr    = mon_valid_i && mon_kind_i == eem_pkg::ACC_WRITE;
    moff     = mon_addr_i - s.init_base;
    inc      = eem_inc(s.tick_sel);

    // Wishbone: ack one cycle after the request, dropped after one cycle
    next_s.ack = req & ~s.ack;
    if (req && !s.ack) begin
      next_s.rdat = wold;
    end

    // Register writes
    if (bus_wr) begin
      if (wwin == eem_pkg::WIN_BLK) begin
        unique case (wfld)
          eem_pkg::FLD_START: next_s.blk_start[widx] = wval[eem_pkg::ADDR_W-1:0];
          eem_pkg::FLD_END:   next_s.blk_end[widx]   = wval[eem_pkg::ADDR_W-1:0];
          eem_pkg::FLD_ATTR: begin
            next_s.blk_attr[widx]  = wval[2:0];
            next_s.blk_valid[widx] = wval[eem_pkg::BLK_VALID_BIT];
          end
          default: ;
        endcase
      end else if (wwin == eem_pkg::WIN_TSTK && widx < 4'(eem_pkg::NUM_TSTK)) begin
        unique case (wfld)
          eem_pkg::FLD_START: next_s.ts_start[widx[1:0]] = wval[eem_pkg::ADDR_W-1:0];
          eem_pkg::FLD_END:   next_s.ts_end[widx[1:0]]   = wval[eem_pkg::ADDR_W-1:0];
          eem_pkg::FLD_ATTR: begin
            next_s.ts_owner[widx[1:0]] = wval[eem_pkg::TASK_W-1:0];
            next_s.ts_valid[widx[1:0]] = wval[eem_pkg::TASK_W];
          end
          default: ;
        endcase
      end else begin
        unique case ({wb_adr_i[11:2], 2'b00})
          eem_pkg::REG_CTRL: begin
            // Unsupported tick codes are ignored, keeping the current setting
            if (wval[2:0] < 3'(eem_pkg::NUM_TICK) && wval[2:0] != s.tick_sel) begin
              next_s.tick_sel = wval[2:0]; // [RL1]
              clr_meas        = 1'b1;      // [RL2]
            end
            next_s.stk_en = wval[eem_pkg::CTRL_STK_EN];
            clr_meas = clr_meas | wval[eem_pkg::CTRL_CLR_MEAS];
            clr_map  = wval[eem_pkg::CTRL_CLR_MAP];
          end
          eem_pkg::REG_STATUS:    w1c              = wval[eem_pkg::NUM_EV-1:0];
          eem_pkg::REG_BRK_SEL:   next_s.brk_sel   = wval[eem_pkg::NUM_EV-1:0];
          eem_pkg::REG_TRC_SEL:   next_s.trc_sel   = wval[eem_pkg::NUM_EV-1:0];
          eem_pkg::REG_STK_LO:    next_s.stk_lo    = wval[eem_pkg::ADDR_W-1:0];
          eem_pkg::REG_STK_HI:    next_s.stk_hi    = wval[eem_pkg::ADDR_W-1:0];
          eem_pkg::REG_INIT_BASE: next_s.init_base = wval[eem_pkg::ADDR_W-1:0];
          default: ; // Counters are read-only; unmapped writes are dropped
        endcase
      end
    end

    // Access protection: fetch counts as a read for write-only words
    if (mon_valid_i) begin
      unique case (attr)
        eem_pkg::ATTR_RO:  ev[eem_pkg::EV_PROT] = is_wr;              // [RL7] [RL17]
        eem_pkg::ATTR_WO:  ev[eem_pkg::EV_PROT] = !is_wr;             // [RL7] [RL17]
        eem_pkg::ATTR_DIS: ev[eem_pkg::EV_PROT] = 1'b1;               // [RL17]
        eem_pkg::ATTR_DOS: ev[eem_pkg::EV_PROT] = !mon_os_i;          // [RL14]
        default:           ev[eem_pkg::EV_PROT] = 1'b0;
      endcase
    end

    // Written-location map over a 256-entry window; set wins over clear
    if (clr_map) begin
      next_s.written = '0;
    end
    if (moff < eem_pkg::ADDR_W'(eem_pkg::MAP_WORDS)) begin
      if (is_rd && !s.written[moff[eem_pkg::MAP_IDX_W-1:0]]) begin
        ev[eem_pkg::EV_UNINI] = 1'b1; // [RL8]
      end
      if (is_wr) begin
        next_s.written[moff[eem_pkg::MAP_IDX_W-1:0]] = 1'b1; // [RL8]
      end
    end

    // Stack bounds, task stacks, trace store and dispatch
    ev[eem_pkg::EV_STACK] = s.stk_en && mon_sp_valid_i && (mon_sp_i < s.stk_lo || mon_sp_i > s.stk_hi); // [RL9]
    ev[eem_pkg::EV_TSTK]  = is_wr && (|ts_hit); // [RL11]
    ev[eem_pkg::EV_TRACE] = trace_wr_i && trace_full_i; // Store attempted with no room [RL10]
    if (mon_task_valid_i) begin
      next_s.task_seen = 1'b1;
      next_s.prev_task = mon_task_i;
      ev[eem_pkg::EV_DISP] = s.task_seen && mon_task_i != s.prev_task; // [RL12]
    end

    // Tick divider: one counting step every eem_div cycles
    tick = (s.divcnt >= eem_div(s.tick_sel) - 6'h01);
    next_s.divcnt = tick ? '0 : s.divcnt + 6'h01;

    // Profile time: saturates at the top so the overflow stays visible
    tsum = {1'b0, s.ptime} + 41'(inc);
    if (prof_run_i && tick) begin
      if (tsum[eem_pkg::PTIME_W]) begin
        next_s.ptime = '1;
        ev[eem_pkg::EV_PROF] = 1'b1; // [RL5]
      end else begin
        next_s.ptime = tsum[eem_pkg::PTIME_W-1:0]; // 40-bit tick count [RL3]
      end
    end
    if (prof_enter_i) begin
      if (&s.pass) begin
        ev[eem_pkg::EV_PROF] = 1'b1; // Entry 65536 exceeds the counter [RL4] [RL5]
      end else begin
        next_s.pass = s.pass + 16'h0001; // [RL4]
      end
    end

    // Section timer for performance measurement
    ssum = {1'b0, s.sect} + 33'(inc);
    if (perf_run_i && tick) begin
      if (ssum[eem_pkg::SECT_W]) begin
        next_s.sect = '1;
        ev[eem_pkg::EV_PERF] = 1'b1; // [RL6]
      end else begin
        next_s.sect = ssum[eem_pkg::SECT_W-1:0];
      end
    end

    // Clearing measurements also restarts the divider phase
    if (clr_meas) begin
      next_s.ptime  = '0; // [RL2]
      next_s.pass   = '0; // [RL2]
      next_s.sect   = '0;
      next_s.divcnt = '0;
    end

    // Sticky flags: a new event beats a same-cycle clear
    next_s.flags = (s.flags & ~w1c) | ev; // [RL19]
    next_s.evp   = ev;                    // [RL19]
    next_s.brk   = |(ev & s.brk_sel);     // [RL18]
    next_s.trc   = |(ev & s.trc_sel);     // [RL18]
  end

  // State register; blocks start invalid so all memory is read-write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s           <= '0;
      s.tick_sel  <= eem_pkg::TICK_RST;
      s.stk_lo    <= eem_pkg::STK_LO_RST;
      s.stk_hi    <= eem_pkg::STK_HI_RST;
      s.blk_attr  <= '0; // Read-write code in every region [RL15]
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  assign wb_dat_o      = s.rdat;
  assign wb_ack_o      = s.ack;
  assign event_pulse_o = s.evp;
  assign event_flags_o = s.flags;
  assign break_o       = s.brk;
  assign trace_o       = s.trc;
endmodule // eem_monitor

// ===== design/eem_pkg.sv
/*
  Constants shared by the emulator exception monitor: register offsets, field
  positions, reset values, attribute and access encodings, event positions and
  the profile tick table. Assumes a 25 MHz emulator clock.
*/
package eem_pkg;
  // Widths and sizes
  localparam int ADDR_W    = 20;
  localparam int DATA_W    = 32;
  localparam int WB_AW     = 12;
  localparam int NUM_BLK   = 16;
  localparam int NUM_TSTK  = 4;
  localparam int TASK_W    = 4;
  localparam int MAP_WORDS = 256;
  localparam int MAP_IDX_W = 8;
  localparam int PTIME_W   = 40;
  localparam int PASS_W    = 16;
  localparam int SECT_W    = 32;
  localparam int NUM_EV    = 8;
  localparam int DIV_W     = 6;

  // Register byte offsets
  localparam logic [WB_AW-1:0] REG_CTRL      = 12'h000;
  localparam logic [WB_AW-1:0] REG_STATUS    = 12'h004;
  localparam logic [WB_AW-1:0] REG_BRK_SEL   = 12'h008;
  localparam logic [WB_AW-1:0] REG_TRC_SEL   = 12'h00C;
  localparam logic [WB_AW-1:0] REG_PTIME_LO  = 12'h010;
  localparam logic [WB_AW-1:0] REG_PTIME_HI  = 12'h014;
  localparam logic [WB_AW-1:0] REG_PASS      = 12'h018;
  localparam logic [WB_AW-1:0] REG_SECT      = 12'h01C;
  localparam logic [WB_AW-1:0] REG_STK_LO    = 12'h020;
  localparam logic [WB_AW-1:0] REG_STK_HI    = 12'h024;
  localparam logic [WB_AW-1:0] REG_INIT_BASE = 12'h028;
  // Windows: block i at 0x100 + 0x10*i, task stack slot i at 0x200 + 0x10*i
  localparam logic [3:0]       WIN_BLK       = 4'h1;
  localparam logic [3:0]       WIN_TSTK      = 4'h2;
  localparam logic [1:0]       FLD_START     = 2'h0;
  localparam logic [1:0]       FLD_END       = 2'h1;
  localparam logic [1:0]       FLD_ATTR      = 2'h2;

  // CTRL fields
  localparam int CTRL_TICK_LSB = 0;
  localparam int CTRL_STK_EN   = 3;
  localparam int CTRL_CLR_MEAS = 4;
  localparam int CTRL_CLR_MAP  = 5;
  // Block attribute register: valid bit above the three-bit code
  localparam int BLK_VALID_BIT = 3;

  // Reset values
  localparam logic [2:0]        TICK_RST   = 3'h0;
  localparam logic [ADDR_W-1:0] STK_LO_RST = 20'h0_0000;
  localparam logic [ADDR_W-1:0] STK_HI_RST = 20'hF_FFFF;

  // Access attribute codes
  localparam logic [2:0] ATTR_RW  = 3'h0;
  localparam logic [2:0] ATTR_RO  = 3'h1;
  localparam logic [2:0] ATTR_WO  = 3'h2;
  localparam logic [2:0] ATTR_DIS = 3'h3;
  localparam logic [2:0] ATTR_DOS = 3'h4;

  // Target access kinds
  localparam logic [1:0] ACC_READ  = 2'h0;
  localparam logic [1:0] ACC_WRITE = 2'h1;
  localparam logic [1:0] ACC_FETCH = 2'h2;

  // Event bit positions
  localparam int EV_PROT  = 0;
  localparam int EV_UNINI = 1;
  localparam int EV_STACK = 2;
  localparam int EV_PERF  = 3;
  localparam int EV_PROF  = 4;
  localparam int EV_TRACE = 5;
  localparam int EV_TSTK  = 6;
  localparam int EV_DISP  = 7;

  // Profile tick table, in ns, and its cycle mapping at the clock period
  localparam int CLK_PERIOD_NS = 40;
  localparam int NUM_TICK      = 6;
  localparam int TICK_NS [NUM_TICK] = '{10, 20, 40, 80, 160, 1600};

  // Ticks added per counting cycle: intervals finer than a clock add several
  function automatic int tick_inc(input int ns);
    return (ns < CLK_PERIOD_NS) ? CLK_PERIOD_NS / ns : 1;
  endfunction

  // Clock cycles per counting step: coarser intervals count every Nth cycle
  function automatic int tick_div(input int ns);
    return (ns > CLK_PERIOD_NS) ? ns / CLK_PERIOD_NS : 1;
  endfunction
endpackage

// ===== verif/eem_monitor_assertions.sv
/*
  Port checker for the exception monitor.
  Assumes one clock; bound in below.
*/
`timescale 1ns/100ps
module eem_monitor_assertions (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic        wb_ack_o,
  input wire logic        mon_valid_i,
  input wire logic        trace_wr_i,
  input wire logic        trace_full_i,
  input wire logic [7:0]  event_pulse_o,
  input wire logic [7:0]  event_flags_o,
  input wire logic        break_o,
  input wire logic        trace_o
);
  logic cfg_w;
  logic stat_wr;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A status write is the only way a flag may drop
  assign stat_wr = wb_cyc_i && wb_ack_o && wb_we_i && wb_adr_i[11:2] == eem_pkg::REG_STATUS[11:2];
  // Writes above the base page may set attributes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_w <= 1'b0;
    end else if (wb_cyc_i && wb_ack_o && wb_we_i && wb_adr_i[11:8] != 4'h0) begin
      cfg_w <= 1'b1;
    end
  end
  ack_next_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  trace_ovf_a: assert property (trace_wr_i && trace_full_i |=> event_pulse_o[eem_pkg::EV_TRACE])
    else $error("trace ovf missed");
  trace_quiet_a: assert property (!(trace_wr_i && trace_full_i) |=> !event_pulse_o[eem_pkg::EV_TRACE])
    else $error("trace ovf spurious");
  pulse_sets_flag_a: assert property ((event_pulse_o & ~event_flags_o) == 8'h00)
    else $error("pulse without flag");
  flag_sticky_a: assert property (|($past(event_flags_o) & ~event_flags_o) |-> $past(stat_wr))
    else $error("flag dropped");
  break_source_a: assert property (break_o || trace_o |-> |event_pulse_o)
    else $error("qualifier without event");
  rw_default_a: assert property (!cfg_w && mon_valid_i |=> !event_pulse_o[0] && !event_pulse_o[6])
    else $error("early violation");
endmodule // eem_monitor_assertions

bind eem_monitor eem_monitor_assertions eem_monitor_assertions_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_ack_o, .mon_valid_i, .trace_wr_i, .trace_full_i, .event_pulse_o,
  .event_flags_o, .break_o, .trace_o);

// ===== verif/eem_monitor_tb.sv
/*
  Bench for the exception monitor, one task per scenario.
  Assumes the target model drives every monitor input.
*/
`timescale 1ns/100ps
module eem_monitor_tb;
  localparam logic [8:0] OS = 9'h100, TF = 9'h080, V = 9'h040, SPV = 9'h020, TV = 9'h010;
  localparam logic [8:0] TW = 9'h008, ENT = 9'h004, RUN = 9'h002, PF = 9'h001;
  localparam logic [1:0] RD = eem_pkg::ACC_READ, WR = eem_pkg::ACC_WRITE;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, got;
  logic [19:0] ma, spd;
  logic [3:0]  tid;
  logic [1:0]  mk;
  logic [7:0]  pulse, flags;
  logic        ack, mv, mo, spv, tv, tw, tf, pr, pe, pf, brk, trc;
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  eem_monitor eem_monitor_i (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .mon_valid_i(mv),
    .mon_kind_i(mk), .mon_addr_i(ma), .mon_os_i(mo), .mon_sp_valid_i(spv), .mon_sp_i(spd),
    .mon_task_valid_i(tv), .mon_task_i(tid), .trace_wr_i(tw), .trace_full_i(tf), .prof_run_i(pr),
    .prof_enter_i(pe), .perf_run_i(pf), .event_pulse_o(pulse), .event_flags_o(flags), .break_o(brk),
    .trace_o(trc));
  eem_target_model m_i (.clk_i, .v_o(mv), .kind_o(mk), .addr_o(ma), .os_o(mo), .spv_o(spv),
    .sp_o(spd), .tv_o(tv), .task_o(tid), .tw_o(tw), .tf_o(tf), .run_o(pr), .ent_o(pe), .perf_o(pf));

  // 40 ns clock and a hang guard well above the pass-count run
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      errors = errors + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Classic single cycle; read data is taken at the ack edge
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    got = rdat;
    cyc <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    wb(0, a, 32'h0000_0000);
    chk(got, e);
  endtask
  // One target cycle, then {break, trace, pulses} checked once settled
  task automatic ev(input logic [8:0] s, input logic [19:0] a, input logic [1:0] k, input logic [9:0] e);
    m_i.hit(s, 1, a, k);
    @(negedge clk_i);
    chk({22'h0, brk, trc, pulse}, {22'h0, e});
  endtask

  task automatic t_regs();
    rd(12'h024, 32'h000F_FFFF);
    ev(V, 20'h0_1800, WR, 10'h000);
    wb(1, 12'h3FC, 32'hFFFF_FFFF);
    rd(12'h3FC, 32'h0000_0000);
  endtask
  task automatic t_prot();
    logic f;
    wb(1, 12'h100, 32'h0000_1000);
    wb(1, 12'h104, 32'h0000_1FFF);
    wb(1, 12'h008, 32'h0000_0001);
    for (int at = 0; at < 5; at++) begin
      wb(1, 12'h108, 32'h0000_0008 + 32'(at));
      for (int k = 0; k < 3; k++) begin
        for (int o = 0; o < 2; o++) begin
          f = (at == eem_pkg::ATTR_RO && k == WR) || at == eem_pkg::ATTR_DIS
              || (at == eem_pkg::ATTR_WO && k != WR) || (at == eem_pkg::ATTR_DOS && o == 0);
          ev(V | (o ? OS : 9'h000), 20'h0_1800, 2'(k), {f, 1'b0, 7'h00, f});
        end
      end
    end
    ev(V, 20'h0_2000, RD, 10'h000);
    rd(12'h004, 32'h0000_0001);
    wb(1, 12'h004, 32'h0000_00FF);
    rd(12'h004, 32'h0000_0000);
  endtask
  task automatic t_uninit();
    wb(1, 12'h028, 32'h0000_0400);
    ev(V, 20'h0_0405, RD, 10'h002);
    ev(V, 20'h0_0405, WR, 10'h000);
    ev(V, 20'h0_0405, RD, 10'h000);
    wb(1, 12'h000, 32'h0000_0020);
    ev(V, 20'h0_0405, RD, 10'h002);
  endtask
  task automatic t_stack();
    wb(1, 12'h020, 32'h0000_0800);
    wb(1, 12'h024, 32'h0000_08FF);
    ev(SPV, 20'h0_0900, 2'h0, 10'h000);
    wb(1, 12'h000, 32'h0000_0008);
    ev(SPV, 20'h0_0900, 2'h0, 10'h004);
    ev(SPV, 20'h0_08FF, 2'h0, 10'h000);
    ev(SPV, 20'h0_07FF, 2'h0, 10'h004);
  endtask
  // Task id rides on the low address nibble
  task automatic t_tstk();
    wb(1, 12'h200, 32'h0000_3000);
    wb(1, 12'h204, 32'h0000_30FF);
    wb(1, 12'h208, 32'h0000_0011);
    ev(TV, 20'h0_0001, 2'h0, 10'h000);
    ev(V | TV, 20'h0_3001, WR, 10'h000);
    ev(V | TV, 20'h0_3002, WR, 10'h0C0);
    ev(V | TV, 20'h0_3012, RD, 10'h000);
  endtask
  task automatic t_trace();
    wb(1, 12'h00C, 32'h0000_0020);
    ev(TW, 20'h0_0000, 2'h0, 10'h000);
    ev(TW | TF, 20'h0_0000, 2'h0, 10'h120);
  endtask
  task automatic t_prof();
    wb(1, 12'h004, 32'h0000_00FF);
    m_i.hit(RUN | PF, 10);
    rd(12'h010, 32'h0000_0028);
    rd(12'h01C, 32'h0000_0028);
    wb(1, 12'h000, 32'h0000_0001);
    rd(12'h010, 32'h0000_0000);
    m_i.hit(RUN, 10);
    rd(12'h010, 32'h0000_0014);
    wb(1, 12'h000, 32'h0000_0004);
    m_i.hit(RUN, 16);
    wb(1, 12'h000, 32'h0000_0006);
    rd(12'h010, 32'h0000_0004);
    rd(12'h014, 32'h0000_0000);
    m_i.hit(ENT, 65535);
    rd(12'h004, 32'h0000_0000);
    ev(ENT, 20'h0_0000, 2'h0, 10'h010);
    rd(12'h018, 32'h0000_FFFF);
    wb(1, 12'h000, 32'h0000_0014);
    rd(12'h018, 32'h0000_0000);
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_prot();
    t_uninit();
    t_stack();
    t_tstk();
    t_trace();
    t_prof();
    finish_test();
  end
endmodule // eem_monitor_tb

// ===== verif/eem_target_model.sv
/*
  Target-side model for the monitor's inputs.
  Assumes the bench calls hit from its main sequence.
*/
`timescale 1ns/100ps
module eem_target_model (
  input  wire logic   clk_i,
  output logic        v_o,
  output logic [1:0]  kind_o,
  output logic [19:0] addr_o,
  output logic        os_o,
  output logic        spv_o,
  output logic [19:0] sp_o,
  output logic        tv_o,
  output logic [3:0]  task_o,
  output logic        tw_o,
  output logic        tf_o,
  output logic        run_o,
  output logic        ent_o,
  output logic        perf_o
);
  // Quiet target at time zero
  initial begin
    {os_o, tf_o, v_o, spv_o, tv_o, tw_o, ent_o, run_o, perf_o, kind_o, addr_o, sp_o, task_o} = '0;
  end
  // Strobes held n cycles, then cleared; address, stack and task lines go inverted so stale values never pass
  task automatic hit(input logic [8:0] s, input int n, input logic [19:0] a = 20'h0_0000, input logic [1:0] k = 2'h0);
    @(posedge clk_i);
    {os_o, tf_o, v_o, spv_o, tv_o, tw_o, ent_o, run_o, perf_o} <= s;
    {kind_o, addr_o, sp_o, task_o} <= {k, a, a, a[3:0]};
    repeat (n) @(posedge clk_i);
    {os_o, tf_o, v_o, spv_o, tv_o, tw_o, ent_o, run_o, perf_o} <= '0;
    {addr_o, sp_o, task_o} <= {~a, ~a, ~a[3:0]};
  endtask
endmodule // eem_target_model
